// ===== hw/adc_regs_pkg.sv
package adc_regs_pkg;

  localparam int DATA_W   = 16;
  localparam int BUS_W    = 32;
  localparam int ADDR_W   = 8;
  localparam int IDX_W    = 6;
  localparam int CHANNELS = 2;

  // word index of each register; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_THR_HIGH  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_THR_LOW   = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CHAN0_CONFIG   = 6'h09;
  localparam logic [IDX_W-1:0] IDX_OFF_HIGH  = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_OFF_LOW   = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_GAIN_HIGH = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_GAIN_LOW  = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CHAN1_CONFIG   = 6'h0E;

  localparam logic [DATA_W-1:0] RST_THR_HIGH  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_THR_LOW   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CFG       = 16'h0000;
  localparam logic [DATA_W-1:0] RST_OFF_HIGH  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_OFF_LOW   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GAIN_HIGH = 16'h8000;
  localparam logic [DATA_W-1:0] RST_GAIN_LOW  = 16'h0000;

  // writable bits; all others are reserved and read as zero
  localparam logic [DATA_W-1:0] WMASK_FULL    = 16'hFFFF;
  localparam logic [DATA_W-1:0] WMASK_THR_LOW = 16'hFF0F;
  localparam logic [DATA_W-1:0] WMASK_CFG     = 16'hFFC7;
  localparam logic [DATA_W-1:0] WMASK_CAL_LOW = 16'hFF00;

  localparam int THR_LOW_LIMIT_LSB = 8;
  localparam int HP_SEL_LSB        = 0;
  localparam int HP_SEL_W          = 4;
  localparam int CFG_SKEW_LSB      = 6;
  localparam int CFG_SKEW_W        = 10;
  localparam int CFG_BYPASS_BIT    = 2;
  localparam int CFG_INSEL_LSB     = 0;
  localparam int CAL_LOW_LSB       = 8;
  localparam int CAL_W             = 24;

  localparam logic [HP_SEL_W-1:0] HP_SEL_OFF = 4'h0;

  typedef enum logic [1:0] {
    INSEL_DIFF_PINS,
    INSEL_SHORTED,
    INSEL_TEST_POS,
    INSEL_TEST_NEG
  } input_select_type;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_type;

endpackage

// ===== hw/reg_access_if.sv
`timescale 1ns/100ps
interface reg_access_if;
  import adc_regs_pkg::*;
  logic                req_valid;
  logic                req_write;
  logic [IDX_W-1:0]    req_index;
  logic [DATA_W-1:0]   req_wdata;
  logic [DATA_W-1:0]   req_wmask;
  logic [DATA_W-1:0]   rsp_rdata;
  modport front (output req_valid, req_write, req_index, req_wdata, req_wmask,
                 input  rsp_rdata);
  modport regs  (input  req_valid, req_write, req_index, req_wdata, req_wmask,
                 output rsp_rdata);
endinterface

// ===== hw/bus_front.sv
`timescale 1ns/100ps
module bus_front
  import adc_regs_pkg::*;
(
  input  wire logic                ref_clk_in,
  input  wire logic                reset_in,
  input  wire logic                clk_en_in,
  input  wire logic [ADDR_W-1:0]   avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [BUS_W-1:0]    avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [BUS_W-1:0]    avs_readdata_out,
  output logic                     avs_waitrequest_out,
  reg_access_if.front              acc
);
  bus_state_type     state_q, state_d;
  logic [BUS_W-1:0]  rdata_q, rdata_d;
  logic              req;

  assign req = avs_read_in | avs_write_in;
  assign acc.req_valid = req & (state_q == BUS_IDLE) & clk_en_in;
  assign acc.req_write = avs_write_in;
  assign acc.req_index = avs_address_in[ADDR_W-1:2];
  assign acc.req_wdata = avs_writedata_in[DATA_W-1:0];
  assign acc.req_wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign avs_waitrequest_out = req & (state_q == BUS_IDLE);
  assign avs_readdata_out    = rdata_q;

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      BUS_IDLE: begin
        if (acc.req_valid) begin
          state_d = BUS_ANSWER;
          rdata_d = avs_read_in ? {16'h0000, acc.rsp_rdata} : 32'h00000000;
        end
      end
      BUS_ANSWER: begin
        state_d = BUS_IDLE;
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q <= BUS_IDLE;
      rdata_q <= 32'h00000000;
    end else if (clk_en_in) begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end
endmodule

// ===== hw/chan_decode.sv
`timescale 1ns/100ps
module chan_decode
  import adc_regs_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   clk_en_in,
  input  wire logic [DATA_W-1:0]      cfg_in,
  input  wire logic [HP_SEL_W-1:0]    coef_sel_in,
  output logic      [CFG_SKEW_W-1:0]  skew_out,
  output logic                        highpass_on_out,
  output logic      [4:0]             highpass_shift_out,
  output logic      [3:0]             route_out
);
  logic [CFG_SKEW_W-1:0] skew_q, skew_d;
  logic                  on_q, on_d;
  logic [4:0]            shift_q, shift_d;
  logic [3:0]            route_q, route_d;
  input_select_type      sel;

  assign sel = input_select_type'(cfg_in[CFG_INSEL_LSB +: 2]);

  always_comb begin
    skew_d  = cfg_in[CFG_SKEW_LSB +: CFG_SKEW_W];
    // filter runs only when selected globally and not bypassed here
    on_d    = (coef_sel_in != HP_SEL_OFF) & ~cfg_in[CFG_BYPASS_BIT];
    // coefficient is 2 to the minus (code + 1)
    shift_d = on_d ? ({1'b0, coef_sel_in} + 5'h01) : 5'h00;
    route_d = 4'h0;
    case (sel)
      INSEL_DIFF_PINS: route_d = 4'h1;
      INSEL_SHORTED:   route_d = 4'h2;
      INSEL_TEST_POS:  route_d = 4'h4;
      INSEL_TEST_NEG:  route_d = 4'h8;
      default:         route_d = 4'h1;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      skew_q  <= 10'h000;
      on_q    <= 1'b0;
      shift_q <= 5'h00;
      route_q <= 4'h1;
    end else if (clk_en_in) begin
      skew_q  <= skew_d;
      on_q    <= on_d;
      shift_q <= shift_d;
      route_q <= route_d;
    end
  end

  assign skew_out           = skew_q;
  assign highpass_on_out    = on_q;
  assign highpass_shift_out = shift_q;
  assign route_out          = route_q;
endmodule

// ===== hw/adc_config_regs.sv
// Operation
// - threshold upper sixteen bits, read/write, reset zero
// - threshold low byte in bits 15:8
// - four-bit highpass coefficient select, zero disables
// - channel A ten-bit signed sample skew
// - bypass bit removes highpass for channel
// - two-bit input select picks pins, short, tests
// - offset bits 23:8 stored, reset zero
// - offset bits 7:0 in low register's top byte
// - gain bits 23:8 stored, reset 8000h
// - gain bits 7:0 in low register's top
// - calibration low registers' bottom byte reads zero
// - words 7h..Dh decode in listed order
// - second channel configuration at Eh, reset zero
`timescale 1ns/100ps
module adc_config_regs (
  input  wire logic                                   ref_clk_in,
  input  wire logic                                   reset_in,
  input  wire logic                                   clk_en_in,
  input  wire logic [adc_regs_pkg::ADDR_W-1:0]        avs_address_in,
  input  wire logic                                   avs_read_in,
  input  wire logic                                   avs_write_in,
  input  wire logic [adc_regs_pkg::BUS_W-1:0]         avs_writedata_in,
  input  wire logic [3:0]                             avs_byteenable_in,
  output logic      [adc_regs_pkg::BUS_W-1:0]         avs_readdata_out,
  output logic                                        avs_waitrequest_out,
  output logic      [adc_regs_pkg::CAL_W-1:0]         detect_limit_out,
  output logic      [adc_regs_pkg::HP_SEL_W-1:0]      highpass_coef_select_out,
  output logic      [adc_regs_pkg::CAL_W-1:0]         chan_a_offset_out,
  output logic      [adc_regs_pkg::CAL_W-1:0]         chan_a_gain_out,
  output logic      [2*adc_regs_pkg::CFG_SKEW_W-1:0]  chan_sample_skew_out,
  output logic      [adc_regs_pkg::CHANNELS-1:0]      chan_highpass_on_out,
  output logic      [2*5-1:0]                         chan_highpass_shift_out,
  output logic      [2*4-1:0]                         chan_input_route_out
);
  import adc_regs_pkg::*;

  reg_access_if acc ();

  bus_front u_front (
    .ref_clk_in          (ref_clk_in),
    .reset_in            (reset_in),
    .clk_en_in           (clk_en_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .acc                 (acc.front)
  );

  // write strobes, one per register
  logic wr;
  logic wr_thr_high;
  logic wr_thr_low;
  logic wr_off_high;
  logic wr_off_low;
  logic wr_gain_high;
  logic wr_gain_low;
  logic [CHANNELS-1:0] wr_cfg;

  assign wr = acc.req_valid & acc.req_write;

  always_comb begin
    wr_thr_high  = 1'b0;
    wr_thr_low   = 1'b0;
    wr_off_high  = 1'b0;
    wr_off_low   = 1'b0;
    wr_gain_high = 1'b0;
    wr_gain_low  = 1'b0;
    wr_cfg       = '0;
    if (acc.req_index == IDX_THR_HIGH) begin
      wr_thr_high = wr;
    end else if (acc.req_index == IDX_THR_LOW) begin
      wr_thr_low = wr;
    end else if (acc.req_index == IDX_CHAN0_CONFIG) begin
      wr_cfg[0] = wr;
    end else if (acc.req_index == IDX_OFF_HIGH) begin
      wr_off_high = wr;
    end else if (acc.req_index == IDX_OFF_LOW) begin
      wr_off_low = wr;
    end else if (acc.req_index == IDX_GAIN_HIGH) begin
      wr_gain_high = wr;
    end else if (acc.req_index == IDX_GAIN_LOW) begin
      wr_gain_low = wr;
    end else if (acc.req_index == IDX_CHAN1_CONFIG) begin
      wr_cfg[1] = wr;
    end
  end

  // merge of old value and lane-masked new data inside writable bits
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [DATA_W-1:0] lanes,
    input logic [DATA_W-1:0] writable
  );
    logic [DATA_W-1:0] m;
    m = lanes & writable;
    return ((old_val & ~m) | (new_val & m)) & writable;
  endfunction

  // current-detect threshold and filter select
  logic [DATA_W-1:0] thr_high_q, thr_high_d;
  logic [DATA_W-1:0] thr_low_q, thr_low_d;

  always_comb begin
    thr_high_d = thr_high_q;
    thr_low_d  = thr_low_q;
    if (wr_thr_high) begin
      thr_high_d = merge(thr_high_q, acc.req_wdata, acc.req_wmask, WMASK_FULL);
    end
    if (wr_thr_low) begin
      thr_low_d = merge(thr_low_q, acc.req_wdata, acc.req_wmask, WMASK_THR_LOW);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      thr_high_q <= RST_THR_HIGH;
      thr_low_q  <= RST_THR_LOW;
    end else if (clk_en_in) begin
      thr_high_q <= thr_high_d;
      thr_low_q  <= thr_low_d;
    end
  end

  // channel configuration words
  logic [DATA_W-1:0] cfg_q [CHANNELS];
  logic [DATA_W-1:0] cfg_d [CHANNELS];

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      cfg_d[c] = cfg_q[c];
      if (wr_cfg[c]) begin
        cfg_d[c] = merge(cfg_q[c], acc.req_wdata, acc.req_wmask, WMASK_CFG);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int c = 0; c < CHANNELS; c++) begin
        cfg_q[c] <= RST_CFG;
      end
    end else if (clk_en_in) begin
      for (int c = 0; c < CHANNELS; c++) begin
        cfg_q[c] <= cfg_d[c];
      end
    end
  end

  // channel A offset and gain calibration
  logic [DATA_W-1:0] off_high_q, off_high_d;
  logic [DATA_W-1:0] off_low_q, off_low_d;
  logic [DATA_W-1:0] gain_high_q, gain_high_d;
  logic [DATA_W-1:0] gain_low_q, gain_low_d;

  always_comb begin
    off_high_d  = off_high_q;
    off_low_d   = off_low_q;
    gain_high_d = gain_high_q;
    gain_low_d  = gain_low_q;
    if (wr_off_high) begin
      off_high_d = merge(off_high_q, acc.req_wdata, acc.req_wmask, WMASK_FULL);
    end
    if (wr_off_low) begin
      off_low_d = merge(off_low_q, acc.req_wdata, acc.req_wmask, WMASK_CAL_LOW);
    end
    if (wr_gain_high) begin
      gain_high_d = merge(gain_high_q, acc.req_wdata, acc.req_wmask, WMASK_FULL);
    end
    if (wr_gain_low) begin
      gain_low_d = merge(gain_low_q, acc.req_wdata, acc.req_wmask, WMASK_CAL_LOW);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      off_high_q  <= RST_OFF_HIGH;
      off_low_q   <= RST_OFF_LOW;
      gain_high_q <= RST_GAIN_HIGH;
      gain_low_q  <= RST_GAIN_LOW;
    end else if (clk_en_in) begin
      off_high_q  <= off_high_d;
      off_low_q   <= off_low_d;
      gain_high_q <= gain_high_d;
      gain_low_q  <= gain_low_d;
    end
  end

  // read mux; unmapped words read zero
  logic [DATA_W-1:0] rdata;

  always_comb begin
    rdata = 16'h0000;
    if (acc.req_index == IDX_THR_HIGH) begin
      rdata = thr_high_q;
    end else if (acc.req_index == IDX_THR_LOW) begin
      rdata = thr_low_q & WMASK_THR_LOW;
    end else if (acc.req_index == IDX_CHAN0_CONFIG) begin
      rdata = cfg_q[0] & WMASK_CFG;
    end else if (acc.req_index == IDX_OFF_HIGH) begin
      rdata = off_high_q;
    end else if (acc.req_index == IDX_OFF_LOW) begin
      rdata = off_low_q & WMASK_CAL_LOW;
    end else if (acc.req_index == IDX_GAIN_HIGH) begin
      rdata = gain_high_q;
    end else if (acc.req_index == IDX_GAIN_LOW) begin
      rdata = gain_low_q & WMASK_CAL_LOW;
    end else if (acc.req_index == IDX_CHAN1_CONFIG) begin
      rdata = cfg_q[1] & WMASK_CFG;
    end
  end

  assign acc.rsp_rdata = rdata;

  assign detect_limit_out =
    {thr_high_q, thr_low_q[THR_LOW_LIMIT_LSB +: 8]};
  assign highpass_coef_select_out = thr_low_q[HP_SEL_LSB +: HP_SEL_W];
  assign chan_a_offset_out = {off_high_q, off_low_q[CAL_LOW_LSB +: 8]};
  assign chan_a_gain_out = {gain_high_q, gain_low_q[CAL_LOW_LSB +: 8]};

  // per-channel decoded controls
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_chan
      chan_decode u_dec (
        .ref_clk_in         (ref_clk_in),
        .reset_in           (reset_in),
        .clk_en_in          (clk_en_in),
        .cfg_in             (cfg_q[g]),
        .coef_sel_in        (thr_low_q[HP_SEL_LSB +: HP_SEL_W]),
        .skew_out           (chan_sample_skew_out[g*CFG_SKEW_W +: CFG_SKEW_W]),
        .highpass_on_out    (chan_highpass_on_out[g]),
        .highpass_shift_out (chan_highpass_shift_out[g*5 +: 5]),
        .route_out          (chan_input_route_out[g*4 +: 4])
      );
    end
  endgenerate
endmodule

// ===== testbench/adc_config_regs_props.sv
`timescale 1ns/100ps
module adc_config_regs_props
  import adc_regs_pkg::*;
(
  input wire logic                    ref_clk_in,
  input wire logic                    reset_in,
  input wire logic                    clk_en_in,
  input wire logic [ADDR_W-1:0]       avs_address_in,
  input wire logic                    avs_read_in,
  input wire logic                    avs_write_in,
  input wire logic [BUS_W-1:0]        avs_writedata_in,
  input wire logic [3:0]              avs_byteenable_in,
  input wire logic [BUS_W-1:0]        avs_readdata_out,
  input wire logic                    avs_waitrequest_out,
  input wire logic [CAL_W-1:0]        detect_limit_out,
  input wire logic [HP_SEL_W-1:0]     highpass_coef_select_out,
  input wire logic [CAL_W-1:0]        chan_a_offset_out,
  input wire logic [CAL_W-1:0]        chan_a_gain_out,
  input wire logic [2*CFG_SKEW_W-1:0] chan_sample_skew_out,
  input wire logic [CHANNELS-1:0]     chan_highpass_on_out,
  input wire logic [2*5-1:0]          chan_highpass_shift_out,
  input wire logic [2*4-1:0]          chan_input_route_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_wr(logic [7:0] a);
    clk_en_in && avs_write_in && avs_waitrequest_out && avs_address_in == a
      && avs_byteenable_in[1:0] == 2'b11;
  endsequence
  sequence s_rd(logic [7:0] a);
    clk_en_in && avs_read_in && avs_waitrequest_out && avs_address_in == a;
  endsequence

  a_wait_one_cycle: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in |=> !avs_waitrequest_out)
    else $error("waitrequest not released one cycle after acceptance");
  a_limit_upper_write: assert property (
    s_wr(8'h1C) |=> detect_limit_out[23:8] == $past(avs_writedata_in[15:0]))
    else $error("threshold upper half not taken from write");
  a_limit_lower_sel: assert property (
    s_wr(8'h20) |=> detect_limit_out[7:0] == $past(avs_writedata_in[15:8])
      && highpass_coef_select_out == $past(avs_writedata_in[3:0]))
    else $error("threshold low byte or coefficient select wrong");
  a_shift_from_code: assert property (
    chan_highpass_on_out[0] && $past(clk_en_in) |-> $past(highpass_coef_select_out) != 4'h0
      && chan_highpass_shift_out[4:0] == {1'b0, $past(highpass_coef_select_out)} + 5'h01)
    else $error("highpass shift does not follow coefficient code");
  a_skew_chan_a: assert property (
    s_wr(8'h24) ##1 clk_en_in |=> chan_sample_skew_out[9:0] == $past(avs_writedata_in[15:6], 2))
    else $error("channel A skew not taken from configuration");
  a_skew_chan_b: assert property (
    s_wr(8'h38) ##1 clk_en_in |=> chan_sample_skew_out[19:10] == $past(avs_writedata_in[15:6], 2))
    else $error("second channel skew not taken from configuration");
  a_route_one_hot: assert property (
    $onehot(chan_input_route_out[3:0]) && $onehot(chan_input_route_out[7:4]))
    else $error("input route not one-hot");
  a_offset_upper: assert property (
    s_wr(8'h28) |=> chan_a_offset_out[23:8] == $past(avs_writedata_in[15:0]))
    else $error("offset upper half not taken from write");
  a_gain_upper: assert property (
    s_wr(8'h30) |=> chan_a_gain_out[23:8] == $past(avs_writedata_in[15:0]))
    else $error("gain upper half not taken from write");
  a_low_byte_zero: assert property (
    s_rd(8'h2C) or s_rd(8'h34) |=> avs_readdata_out[7:0] == 8'h00)
    else $error("reserved calibration byte read nonzero");
  a_unmapped_zero: assert property (
    s_rd(8'h3C) or s_rd(8'h00) |=> avs_readdata_out == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
endmodule

bind adc_config_regs adc_config_regs_props props_chk (
  .ref_clk_in, .reset_in, .clk_en_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .detect_limit_out, .highpass_coef_select_out, .chan_a_offset_out, .chan_a_gain_out,
  .chan_sample_skew_out, .chan_highpass_on_out, .chan_highpass_shift_out,
  .chan_input_route_out);

// ===== testbench/adc_config_regs_test.sv
`timescale 1ns/100ps
module adc_config_regs_test;
  import adc_regs_pkg::*;
  typedef struct {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic [15:0] rdata;
  } row_type;
  logic        ref_clk_in        = 1'b0;
  logic        reset_in          = 1'b1;
  logic        clk_en_in         = 1'b1;
  logic [7:0]  avs_address_in    = 8'h00;
  logic        avs_read_in       = 1'b0;
  logic        avs_write_in      = 1'b0;
  logic [31:0] avs_writedata_in  = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [23:0] detect_limit_out;
  logic [3:0]  highpass_coef_select_out;
  logic [23:0] chan_a_offset_out;
  logic [23:0] chan_a_gain_out;
  logic [19:0] chan_sample_skew_out;
  logic [1:0]  chan_highpass_on_out;
  logic [9:0]  chan_highpass_shift_out;
  logic [7:0]  chan_input_route_out;
  logic [31:0] got;
  int          num_errors = 0;
  int          compares   = 0;
  row_type     rows [10] = '{
    '{8'h1C, 16'hABCD, 2'b11, 16'hABCD}, '{8'h20, 16'h12F5, 2'b11, 16'h1205},
    '{8'h24, 16'hFFFF, 2'b11, 16'hFFC7}, '{8'h28, 16'h1234, 2'b11, 16'h1234},
    '{8'h2C, 16'h56FF, 2'b11, 16'h5600}, '{8'h30, 16'h9ABC, 2'b11, 16'h9ABC},
    '{8'h34, 16'hDEFF, 2'b11, 16'hDE00}, '{8'h38, 16'hA5A1, 2'b11, 16'hA581},
    '{8'h3C, 16'h1111, 2'b11, 16'h0000}, '{8'h20, 16'hFF03, 2'b01, 16'h1203}};

  always #20 ref_clk_in = ~ref_clk_in;

  adc_config_regs DUT (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .detect_limit_out(detect_limit_out),
    .highpass_coef_select_out(highpass_coef_select_out),
    .chan_a_offset_out(chan_a_offset_out), .chan_a_gain_out(chan_a_gain_out),
    .chan_sample_skew_out(chan_sample_skew_out),
    .chan_highpass_on_out(chan_highpass_on_out),
    .chan_highpass_shift_out(chan_highpass_shift_out),
    .chan_input_route_out(chan_input_route_out));

  task automatic compare_val(input logic [31:0] actual, input logic [31:0] expected);
    compares++;
    if (actual !== expected) begin
      num_errors++;
      $display("[FAIL] time %0t got %h expected %h", $time, actual, expected);
    end
  endtask

  // one Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address_in    <= a;
    avs_write_in      <= wr;
    avs_read_in       <= !wr;
    avs_writedata_in  <= {16'h0000, d};
    avs_byteenable_in <= {2'b00, be};
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 100) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 100) num_errors++;
    rd = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic rd16(input logic [7:0] a, input logic [31:0] expected);
    logic [31:0] v;
    bus(1'b0, a, 16'h0000, 2'b00, v);
    compare_val(v, expected);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk_in);
    num_errors++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd16(8'h1C + 8'(4 * i), (i == 5) ? 32'h8000 : 32'h0);
    end
    compare_val({8'h00, chan_a_gain_out}, 32'h0080_0000);
    compare_val({22'h0, chan_input_route_out, chan_highpass_on_out}, 32'h44);
    $display("reset values done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, got);
      rd16(rows[i].addr, {16'h0000, rows[i].rdata});
    end
    compare_val({8'h00, detect_limit_out}, 32'h00AB_CD12);
    compare_val({8'h00, chan_a_offset_out}, 32'h0012_3456);
    compare_val({8'h00, chan_a_gain_out}, 32'h009A_BCDE);
    compare_val({12'h0, chan_sample_skew_out}, 32'h000A_5BFF);
    compare_val({12'h0, chan_highpass_shift_out, chan_input_route_out, chan_highpass_on_out},
                32'h0002_00A2);
    $display("register table done");
    bus(1'b1, 8'h24, 16'h0000, 2'b11, got);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 8'h20, {12'h120, 4'(c)}, 2'b11, got);
      compare_val({26'h0, chan_highpass_on_out[0], chan_highpass_shift_out[4:0]},
                  (c == 0) ? 32'h0 : 32'h20 + 32'(c + 1));
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h24, 16'(m), 2'b11, got);
      compare_val({28'h0, chan_input_route_out[3:0]}, 32'h1 << m);
    end
    $display("code sweeps done");
    rd16(8'h00, 32'h0);
    clk_en_in <= 1'b0;
    fork
      bus(1'b0, 8'h30, 16'h0000, 2'b00, got);
      begin
        repeat (3) @(posedge ref_clk_in);
        compare_val({31'h0, avs_waitrequest_out}, 32'h1);
        clk_en_in <= 1'b1;
      end
    join
    compare_val(got, 32'h9ABC);
    $display("stall done");
    reset_in <= 1'b1;
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd16(8'h30, 32'h8000);
    rd16(8'h24, 32'h0000);
    compare_val({8'h00, chan_a_gain_out}, 32'h0080_0000);
    $display("second reset done");
    test_done;
  end
endmodule
